// >>> logic/ccd_cfg_top.sv
`default_nettype none
// Functional notes
// R1 - Software writes zeros to reserved bits
// R2 - Chop settle waits 2^(n+1) modulator periods
// R3 - Settle delay code resets to three
// R4 - Chop enable bit, resets off
// R5 - Qualify detect on any or all channels
// R6 - Current detect enable bit, resets off
// R7 - Exceed count code sets 2^n trigger count
// R8 - Window code selects conversion period length
module ccd_cfg_top
  import ccd_pkg::*;
#(
  parameter int NCH = 8
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // Register port
  input  wire logic [7:0]     addr,
  input  wire logic [15:0]    wdata,
  input  wire logic           wr,
  input  wire logic           rd,
  output logic [15:0]         rdata,
  // Converter timing
  input  wire logic           mod_tick,
  input  wire logic           chop_phase_start,
  input  wire logic           conv_done,
  input  wire logic [NCH-1:0] chan_exceed,
  // Results
  output logic                chop_enable,
  output logic                settling,
  output logic                measure_start,
  output logic                detect_pulse,
  output logic                irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]  rsvd;
    logic [3:0]  dly;
    logic        chop_en;
    logic        all_sel;
    logic [2:0]  num;
    logic [2:0]  len;
    logic        overcurrent_watch_enable;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic [15:0] rdata;
    logic        irq;
    logic [11:0] win_cnt;
    logic [7:0]  exc_cnt;
    logic        fired;
    logic        detect;
  } ccd_top_s;

  ccd_top_s q;
  ccd_top_s d;

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  logic tmr_busy;
  logic tmr_done;
  logic qual;
  logic [7:0] target;
  logic [15:0] cfg_word;
  logic [NCH:0] any_chain;
  logic [NCH:0] all_chain;

  // ----------------------------------------
  // Settle timer
  // ----------------------------------------
  // R2 - settling delay count
  // Abort wins over start, so a cleared enable never waits
  ccd_settle_timer u_tmr (
    .clk   (clk),
    .nrst  (nrst),
    .start (q.chop_en && chop_phase_start),
    .abort (!q.chop_en),
    .tick  (mod_tick),
    .code  (q.dly),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  // ----------------------------------------
  // Readback word
  // ----------------------------------------
  // Assembled config word for readback
  assign cfg_word = {q.rsvd, q.dly, q.chop_en, q.all_sel, q.num, q.len, q.overcurrent_watch_enable};

  // ----------------------------------------
  // Channel qualification
  // ----------------------------------------
  // Any and all chains, one stage per channel
  assign any_chain[0] = 1'b0;
  assign all_chain[0] = 1'b1;
  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    assign any_chain[ch+1] = any_chain[ch] | chan_exceed[ch];
    assign all_chain[ch+1] = all_chain[ch] & chan_exceed[ch];
  end

  // R5 - any or all channel qualification
  assign qual   = q.all_sel ? all_chain[NCH] : any_chain[NCH];
  // R7 - trigger count from code
  // Compared with the count plus this hit, so the 2^n-th hit fires
  assign target = CCD_EXC_ONE << q.num;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d        = q;
    d.rdata  = '0;
    d.detect = 1'b0;

    // --------------------------------------
    // Register writes
    // --------------------------------------
    if (wr) begin
      case (addr)
        CCD_ADDR_CFG: begin
          d.rsvd    = wdata[CCD_RSVD_LSB +: 3];
          d.dly     = wdata[CCD_DLY_LSB +: 4];
          // R4 - chop enable write
          d.chop_en = wdata[CCD_CHOP_BIT];
          d.all_sel = wdata[CCD_ALL_BIT];
          d.num     = wdata[CCD_NUM_LSB +: 3];
          d.len     = wdata[CCD_LEN_LSB +: 3];
          // R6 - detect enable write
          d.overcurrent_watch_enable   = wdata[CCD_CDEN_BIT];
        end
        CCD_ADDR_ISTS: d.sts = q.sts & ~wdata[1:0];   // Write one to clear
        CCD_ADDR_IMSK: d.msk = wdata[1:0];
        default: ;
      endcase
    end

    // --------------------------------------
    // Register reads, data one cycle later
    // --------------------------------------
    // Unmapped reads return zero, never stall
    if (rd) begin
      case (addr)
        CCD_ADDR_CFG:  d.rdata = cfg_word;
        CCD_ADDR_ISTS: d.rdata = {14'h0000, q.sts};
        CCD_ADDR_IMSK: d.rdata = {14'h0000, q.msk};
        CCD_ADDR_STAT: d.rdata = {7'h00, tmr_busy, q.exc_cnt};
        default:       d.rdata = 16'h0000;
      endcase
    end

    // --------------------------------------
    // Current detect window and exceed counting
    // --------------------------------------
    // R6 - detect logic idle when disabled
    if (!q.overcurrent_watch_enable) begin
      d.win_cnt = '0;
      d.exc_cnt = '0;
      d.fired   = 1'b0;
    end else if (conv_done) begin
      // Saturates so a long window cannot wrap the count
      if (qual && (q.exc_cnt != CCD_EXC_MAX)) begin
        d.exc_cnt = q.exc_cnt + CCD_EXC_ONE;
      end
      // R7 - fire once count reached
      if (qual && !q.fired && ((q.exc_cnt + CCD_EXC_ONE) >= target)) begin
        d.detect = 1'b1;
        d.fired  = 1'b1;
      end
      // R8 - window end restarts count
      // Last conversion of a window still counts
      if (q.win_cnt == (CCD_WIN_LEN[q.len] - 12'h001)) begin
        d.win_cnt = '0;
        d.exc_cnt = '0;
        d.fired   = 1'b0;
      end else begin
        d.win_cnt = q.win_cnt + 12'h001;
      end
    end

    // --------------------------------------
    // Sticky events, set wins over clear
    // --------------------------------------
    if (d.detect) begin
      d.sts[CCD_EV_DETECT] = 1'b1;
    end
    if (tmr_done) begin
      d.sts[CCD_EV_SETTLE] = 1'b1;
    end
    // Irq follows the next status, no extra cycle
    d.irq = |(d.sts & d.msk);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q         <= '0;
      // R3 - delay code reset value
      q.rsvd    <= CCD_RSVD_RST;
      q.dly     <= CCD_DLY_RST;
      q.chop_en <= CCD_CHOP_RST;
      q.all_sel <= CCD_ALL_RST;
      q.num     <= CCD_NUM_RST;
      q.len     <= CCD_LEN_RST;
      q.overcurrent_watch_enable   <= CCD_CDEN_RST;
      q.sts     <= CCD_IRQ_RST;
      q.msk     <= CCD_IRQ_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs straight from flops
  // ----------------------------------------
  assign rdata         = q.rdata;
  assign chop_enable   = q.chop_en;
  assign settling      = tmr_busy;
  assign measure_start = tmr_done;
  assign detect_pulse  = q.detect;
  assign irq           = q.irq;

endmodule : ccd_cfg_top
`default_nettype wire

// >>> logic/ccd_pkg.sv
`default_nettype none
package ccd_pkg;

  // ----------------------------------------
  // Register map (register index addresses)
  // ----------------------------------------
  localparam logic [7:0]  CCD_ADDR_CFG   = 8'h06;
  localparam logic [7:0]  CCD_ADDR_ISTS  = 8'h10;
  localparam logic [7:0]  CCD_ADDR_IMSK  = 8'h11;
  localparam logic [7:0]  CCD_ADDR_STAT  = 8'h12;

  // ----------------------------------------
  // Global config field positions
  // ----------------------------------------
  localparam int CCD_RSVD_LSB  = 13;
  localparam int CCD_DLY_LSB   = 9;
  localparam int CCD_CHOP_BIT  = 8;
  localparam int CCD_ALL_BIT   = 7;
  localparam int CCD_NUM_LSB   = 4;
  localparam int CCD_LEN_LSB   = 1;
  localparam int CCD_CDEN_BIT  = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CCD_CFG_RST    = 16'h0600;
  localparam logic [2:0]  CCD_RSVD_RST   = 3'h0;
  localparam logic [3:0]  CCD_DLY_RST    = 4'h3;
  localparam logic        CCD_CHOP_RST   = 1'b0;
  localparam logic        CCD_ALL_RST    = 1'b0;
  localparam logic [2:0]  CCD_NUM_RST    = 3'h0;
  localparam logic [2:0]  CCD_LEN_RST    = 3'h0;
  localparam logic        CCD_CDEN_RST   = 1'b0;
  localparam logic [1:0]  CCD_IRQ_RST    = 2'h0;

  // ----------------------------------------
  // Interrupt status bit positions
  // ----------------------------------------
  localparam int CCD_EV_DETECT = 0;
  localparam int CCD_EV_SETTLE = 1;

  // ----------------------------------------
  // Counts
  // ----------------------------------------
  // Settle counter: up to 65536 modulator periods
  localparam int          CCD_SETTLE_W   = 17;
  localparam logic [16:0] CCD_SETTLE_ONE = 17'h00001;
  // Exceed target: 1 shifted by the count code, max 128
  localparam logic [7:0]  CCD_EXC_ONE    = 8'h01;
  localparam logic [7:0]  CCD_EXC_MAX    = 8'hFF;
  // Watch window lengths in conversion periods, by code
  localparam logic [7:0][11:0] CCD_WIN_LEN = {
    12'hE00, 12'hA00, 12'h700, 12'h500, 12'h300, 12'h200, 12'h100, 12'h080
  };

endpackage : ccd_pkg
`default_nettype wire

// >>> logic/ccd_settle_timer.sv
`default_nettype none
module ccd_settle_timer
  import ccd_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       tick,
  input  wire logic [3:0] code,
  // Status
  output logic            busy,
  output logic            done
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [CCD_SETTLE_W-1:0] cnt;
    logic                    busy;
    logic                    done;
  } ccd_tmr_s;

  ccd_tmr_s q;
  ccd_tmr_s d;

  // Countdown of 2^(code+1) modulator ticks
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (abort) begin
      d.busy = 1'b0;
      d.cnt  = '0;
    end else if (start) begin
      d.busy = 1'b1;
      d.cnt  = CCD_SETTLE_ONE << (5'(code) + 5'd1);
    end else if (q.busy && tick) begin
      d.cnt = q.cnt - CCD_SETTLE_ONE;
      if (q.cnt == CCD_SETTLE_ONE) begin
        d.busy = 1'b0;
        d.done = 1'b1;        // Measurement may begin
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;

endmodule : ccd_settle_timer
`default_nettype wire

// >>> bench/ccd_cfg_top_properties.sv
`default_nettype none
module ccd_cfg_props
  import ccd_pkg::*;
#(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic           clk,
  input wire logic           nrst,
  // Register port
  input wire logic [7:0]     addr,
  input wire logic [15:0]    wdata,
  input wire logic           wr,
  input wire logic           rd,
  input wire logic [15:0]    rdata,
  // Converter timing
  input wire logic           mod_tick,
  input wire logic           chop_phase_start,
  input wire logic           conv_done,
  input wire logic [NCH-1:0] chan_exceed,
  // Results
  input wire logic           chop_enable,
  input wire logic           settling,
  input wire logic           measure_start,
  input wire logic           detect_pulse,
  input wire logic           irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------
  // Checks
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_RST_OUT: assert property (!$past(nrst) |-> !settling && !irq && !chop_enable)
    else $error("outputs busy after reset");
  AST_CHOP_WR: assert property (wr && addr == CCD_ADDR_CFG
    |=> chop_enable == $past(wdata[CCD_CHOP_BIT])) else $error("chop enable lost");
  AST_START: assert property (chop_phase_start && chop_enable |=> settling)
    else $error("settle did not start");
  AST_OFF: assert property (!chop_enable [*2] |-> !settling)
    else $error("settling while chop off");
  AST_MS_END: assert property (measure_start |-> $past(mod_tick) && $past(settling))
    else $error("measure start without tick");
  AST_MS_ONE: assert property (measure_start |-> !settling ##1 !measure_start)
    else $error("measure start too long");
  AST_DET_CAUSE: assert property (detect_pulse |-> $past(conv_done) && $past(chan_exceed) != '0)
    else $error("detect without exceed");
  AST_DET_ONE: assert property (detect_pulse |=> !detect_pulse)
    else $error("detect pulse too long");
  AST_RD_CFG: assert property ($past(rd) && $past(addr) == CCD_ADDR_CFG
    |-> rdata[CCD_CHOP_BIT] == chop_enable) else $error("chop bit readback");
  // Main scenarios seen
  cover property (measure_start);
  cover property (detect_pulse);
  cover property (irq);
endmodule : ccd_cfg_props

bind ccd_cfg_top ccd_cfg_props #(.NCH(NCH)) chk_u (.clk(clk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mod_tick(mod_tick),
  .chop_phase_start(chop_phase_start), .conv_done(conv_done), .chan_exceed(chan_exceed),
  .chop_enable(chop_enable), .settling(settling), .measure_start(measure_start),
  .detect_pulse(detect_pulse), .irq(irq));
`default_nettype wire

// >>> bench/chop_and_current_detect_cfg_tb_top.sv
`default_nettype none
module chop_and_current_detect_cfg_tb_top
  import ccd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // Bench signals
  logic        clk, nrst, wr, rd, tk, cps, cd;
  logic [7:0]  addr, ce;
  logic [15:0] wdata, rdata;
  logic        chop_enable, settling, measure_start, detect_pulse, irq;
  int          err_count, check_count, cyc;

  ccd_cfg_top #(.NCH(8)) dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .mod_tick(tk), .chop_phase_start(cps),
    .conv_done(cd), .chan_exceed(ce), .chop_enable(chop_enable), .settling(settling),
    .measure_start(measure_start), .detect_pulse(detect_pulse), .irq(irq));

  // --------------------------------
  // Clock and watchdog
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
  end

  // --------------------------------
  // Tasks
  // --------------------------------
  task summarize;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16
  task chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk1
  task wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk16(rdata, e);
  endtask : rchk
  task conv(input logic [7:0] ex, input logic e);
    @(posedge clk);
    cd <= 1'b1;
    ce <= ex;
    @(posedge clk);
    cd <= 1'b0;
    #1 chk1(detect_pulse, e);
  endtask : conv
  task setdet(input logic [15:0] v);
    wreg(CCD_ADDR_CFG, 16'h0000);
    wreg(CCD_ADDR_CFG, v);
  endtask : setdet
  // Start a settle wait and count ticks until measurement starts
  task settle(input int c);
    int n;
    wreg(CCD_ADDR_CFG, 16'(c << 9) | 16'h0100);
    @(posedge clk);
    cps <= 1'b1;
    @(posedge clk);
    cps <= 1'b0;
    #1 chk1(settling, 1'b1);
    n = 0;
    while (n < 40 && measure_start !== 1'b1) begin
      @(posedge clk);
      tk <= 1'b1;
      @(posedge clk);
      tk <= 1'b0;
      n++;
      #1;
    end
    chk16(16'(n), 16'(2 << c));
    chk1(measure_start, 1'b1);
  endtask : settle

  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    {nrst, wr, rd, tk, cps, cd, addr, ce, wdata} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rchk(CCD_ADDR_CFG, CCD_CFG_RST);
    rchk(8'h07, 16'h0000);
    wreg(CCD_ADDR_CFG, 16'h1F81);
    rchk(CCD_ADDR_CFG, 16'h1F81);
    chk1(chop_enable, 1'b1);
    for (int c = 0; c < 5; c++) settle(c);
    wreg(CCD_ADDR_CFG, 16'h0000);
    @(posedge clk);
    cps <= 1'b1;
    @(posedge clk);
    cps <= 1'b0;
    #1 chk1(settling, 1'b0);
    chk1(chop_enable, 1'b0);
    conv(8'hFF, 1'b0);
    wreg(CCD_ADDR_IMSK, 16'h0001);
    setdet(16'h0001);
    conv(8'h01, 1'b1);
    @(posedge clk);
    #1 chk1(irq, 1'b1);
    // Settle done bit stays sticky from the chop tests
    rchk(CCD_ADDR_ISTS, 16'h0003);
    wreg(CCD_ADDR_ISTS, 16'h0001);
    rchk(CCD_ADDR_ISTS, 16'h0002);
    chk1(irq, 1'b0);
    setdet(16'h0081);
    conv(8'h7F, 1'b0);
    conv(8'hFF, 1'b1);
    setdet(16'h0011);
    conv(8'h01, 1'b0);
    conv(8'h00, 1'b0);
    conv(8'h02, 1'b1);
    setdet(16'h0011);
    conv(8'h01, 1'b0);
    repeat (127) conv(8'h00, 1'b0);
    conv(8'h01, 1'b0);
    conv(8'h01, 1'b1);
    rchk(CCD_ADDR_STAT, 16'h0002);
    // Second reset in mid-run
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk(CCD_ADDR_CFG, CCD_CFG_RST);
    chk1(irq, 1'b0);
    summarize();
  end
endmodule : chop_and_current_detect_cfg_tb_top
`default_nettype wire
